// ===== src/udmats_map.vh
`ifndef UDMATS_MAP_VH
`define UDMATS_MAP_VH

// Register indices; byte address is four times the index
`define UDMATS_IDX_SYNC_EN      8'h48
`define UDMATS_IDX_CYCLE_TIMING 8'h4a
`define UDMATS_IDX_CLK_CFG      8'h54
`define UDMATS_IDX_STATUS       8'h60

// Reset values
`define UDMATS_RST_SYNC_EN      8'h00
`define UDMATS_RST_CYCLE_TIMING 16'h0000
`define UDMATS_RST_CLK_CFG      16'h0000

// Used bits of each register
`define UDMATS_MASK_SYNC_EN      8'h0f
`define UDMATS_MASK_CYCLE_TIMING 16'h3333
`define UDMATS_MASK_CLK_CFG      16'hf00f

// Field positions
`define UDMATS_SEL_SEC_DRV1_LSB  12
`define UDMATS_SEL_SEC_DRV0_LSB  8
`define UDMATS_SEL_PRI_DRV1_LSB  4
`define UDMATS_SEL_PRI_DRV0_LSB  0
`define UDMATS_BASE_CLK_LSB      0
`define UDMATS_FAST_CLK_LSB      12

// Selector encodings
`define UDMATS_SEL_00 2'h0
`define UDMATS_SEL_01 2'h1
`define UDMATS_SEL_10 2'h2

// Cycle time and ready-to-stop counts in base clocks
`define UDMATS_CT_33_00 3'h4
`define UDMATS_RP_33_00 5'h06
`define UDMATS_CT_33_01 3'h3
`define UDMATS_RP_33_01 5'h05
`define UDMATS_CT_33_10 3'h2
`define UDMATS_RP_33_10 5'h04
`define UDMATS_CT_66_01 3'h3
`define UDMATS_CT_66_10 3'h2
`define UDMATS_RP_66    5'h08
`define UDMATS_CT_133   3'h3
`define UDMATS_RP_133   5'h10

`endif

// ===== src/udmats_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "udmats_map.vh"

module udmats_decode (
   input  wire [1:0] cycle_sel,
   input  wire       base_clk_sel,
   input  wire       fast_clk_sel,
   output reg  [2:0] strobe_cycle_time,
   output reg  [4:0] ready_to_stop_time,
   output reg        sel_valid
);

   always @* begin
      strobe_cycle_time  = 3'h0;
      ready_to_stop_time = 5'h00;
      sel_valid          = 1'b0;
      if (fast_clk_sel) begin
         if (cycle_sel == `UDMATS_SEL_01) begin
            strobe_cycle_time  = `UDMATS_CT_133; // R7
            ready_to_stop_time = `UDMATS_RP_133; // R7
            sel_valid          = 1'b1; // R9
         end
      end else if (base_clk_sel) begin
         case (cycle_sel) // R8
            `UDMATS_SEL_01: begin
               strobe_cycle_time  = `UDMATS_CT_66_01; // R6
               ready_to_stop_time = `UDMATS_RP_66; // R6
               sel_valid          = 1'b1;
            end
            `UDMATS_SEL_10: begin
               strobe_cycle_time  = `UDMATS_CT_66_10; // R6
               ready_to_stop_time = `UDMATS_RP_66; // R6
               sel_valid          = 1'b1;
            end
            default: begin
               sel_valid = 1'b0;
            end
         endcase
      end else begin
         case (cycle_sel)
            `UDMATS_SEL_00: begin
               strobe_cycle_time  = `UDMATS_CT_33_00; // R5
               ready_to_stop_time = `UDMATS_RP_33_00; // R5
               sel_valid          = 1'b1;
            end
            `UDMATS_SEL_01: begin
               strobe_cycle_time  = `UDMATS_CT_33_01; // R5
               ready_to_stop_time = `UDMATS_RP_33_01; // R5
               sel_valid          = 1'b1;
            end
            `UDMATS_SEL_10: begin
               strobe_cycle_time  = `UDMATS_CT_33_10; // R5
               ready_to_stop_time = `UDMATS_RP_33_10; // R5
               sel_valid          = 1'b1;
            end
            default: begin
               sel_valid = 1'b0;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// ===== src/udmats_strobe_timer.v
`timescale 1ns/1ps
`default_nettype none

module udmats_strobe_timer (
   input  wire       core_clk,
   input  wire       arst_n,
   input  wire       start,
   input  wire       stop,
   input  wire [2:0] strobe_cycle_time,
   input  wire [4:0] ready_to_stop_time,
   input  wire       dmardy_n,
   output reg        active_q,
   output reg        strobe_q,
   output reg        stop_ok_q
);

   reg [2:0] ct_q;
   reg [4:0] rp_q;
   reg [2:0] cyc_cnt_q;
   reg [4:0] rp_cnt_q;

   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         active_q  <= 1'b0;
         strobe_q  <= 1'b0;
         stop_ok_q <= 1'b0;
         ct_q      <= 3'h0;
         rp_q      <= 5'h00;
         cyc_cnt_q <= 3'h0;
         rp_cnt_q  <= 5'h00;
      end else begin
         strobe_q <= 1'b0;
         if (stop) begin
            active_q  <= 1'b0;
            stop_ok_q <= 1'b0;
         end else if (start && !active_q) begin
            active_q  <= 1'b1;
            ct_q      <= strobe_cycle_time;
            rp_q      <= ready_to_stop_time;
            cyc_cnt_q <= 3'h1;
            rp_cnt_q  <= 5'h00;
            stop_ok_q <= 1'b0;
         end else if (active_q) begin
            if (!dmardy_n) begin
               rp_cnt_q  <= 5'h00;
               stop_ok_q <= 1'b0;
               // Strobe no faster than the minimum cycle
               if (cyc_cnt_q >= ct_q) begin
                  strobe_q  <= 1'b1;
                  cyc_cnt_q <= 3'h1;
               end else begin
                  cyc_cnt_q <= cyc_cnt_q + 3'h1;
               end
            end else begin
               // Drive paused: count to the ready-to-stop point
               if (cyc_cnt_q < ct_q) begin
                  cyc_cnt_q <= cyc_cnt_q + 3'h1;
               end
               if (rp_cnt_q >= rp_q) begin
                  stop_ok_q <= 1'b1;
               end else begin
                  rp_cnt_q <= rp_cnt_q + 5'h01;
               end
            end
         end
      end
   end

endmodule
`default_nettype wire

// ===== src/udmats_top.v
// Overview of operation
// R1: Two-bit selector holds secondary drive 1 strobe cycle and ready-to-stop timing.
// R2: Two-bit selector holds secondary drive 0 strobe cycle and ready-to-stop timing.
// R3: Two-bit selector holds primary drive 1 strobe cycle and ready-to-stop timing.
// R4: Two-bit selector holds primary drive 0 strobe cycle and ready-to-stop timing.
// R5: 33 MHz base: 00 is 4/6, 01 is 3/5, 10 is 2/4 clocks; 11 reserved.
// R6: 66 MHz base: 01 is 3/8, 10 is 2/8 clocks; others reserved.
// R7: 133 MHz fast base: only 01 valid, 3/16 clocks.
// R8: Base clock bit picks 33 MHz when clear, 66 MHz when set.
// R9: Fast clock bit set overrides base clock bit for that drive.
// R10: Synchronous timing applies only while the drive's enable bit is set.
// R11: Software must avoid reserved selector codes for the clock in use.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "udmats_map.vh"

module udmats_top (
   input  wire        core_clk,
   input  wire        arst_n,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [9:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   input  wire        xfer_start,
   input  wire [1:0]  xfer_drive,
   input  wire        xfer_stop,
   input  wire        dmardy_n,
   output wire        xfer_active,
   output wire        strobe_pulse,
   output wire        stop_allowed,
   output wire        xfer_refused
);

   localparam NUM_DRV = 4;

   reg  [15:0] udma_cycle_timing_q;
   reg  [7:0]  sync_en_q;
   reg  [15:0] clk_cfg_q;
   reg  [1:0]  act_drive_q;
   reg         refused_q;

   wire [7:0]  wb_idx;
   wire        wb_req;
   wire        wb_wr;
   wire [11:0] ct_all;
   wire [19:0] rp_all;
   wire [3:0]  valid_all;
   wire [3:0]  ok_all;
   wire [7:0]  sel_all;
   wire [2:0]  sel_ct;
   wire [4:0]  sel_rp;
   wire        start_ok;
   wire        tmr_active;
   wire [15:0] cyc_mask;
   wire [15:0] clk_mask;

   // Masks held on wires so that byte lanes can be sliced from them
   assign cyc_mask = `UDMATS_MASK_CYCLE_TIMING;
   assign clk_mask = `UDMATS_MASK_CLK_CFG;

   assign wb_idx = wb_adr_i[9:2];
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wb_wr  = wb_req & wb_we_i;

   assign sel_all = {udma_cycle_timing_q[`UDMATS_SEL_SEC_DRV1_LSB +: 2], // R1
                     udma_cycle_timing_q[`UDMATS_SEL_SEC_DRV0_LSB +: 2], // R2
                     udma_cycle_timing_q[`UDMATS_SEL_PRI_DRV1_LSB +: 2], // R3
                     udma_cycle_timing_q[`UDMATS_SEL_PRI_DRV0_LSB +: 2]}; // R4

   genvar g;
   generate
      for (g = 0; g < NUM_DRV; g = g + 1) begin : g_drv
         udmats_decode u_dec (
            .cycle_sel          (sel_all[2*g +: 2]),
            .base_clk_sel       (clk_cfg_q[`UDMATS_BASE_CLK_LSB + g]),
            .fast_clk_sel       (clk_cfg_q[`UDMATS_FAST_CLK_LSB + g]),
            .strobe_cycle_time  (ct_all[3*g +: 3]),
            .ready_to_stop_time (rp_all[5*g +: 5]),
            .sel_valid          (valid_all[g])
         );
         assign ok_all[g] = valid_all[g] & sync_en_q[g]; // R10
      end
   endgenerate

   assign sel_ct   = ct_all[3*xfer_drive +: 3];
   assign sel_rp   = rp_all[5*xfer_drive +: 5];
   // Reserved codes are refused rather than timed
   assign start_ok = xfer_start & ok_all[xfer_drive]; // R10

   udmats_strobe_timer u_tmr (
      .core_clk           (core_clk),
      .arst_n             (arst_n),
      .start              (start_ok),
      .stop               (xfer_stop),
      .strobe_cycle_time  (sel_ct),
      .ready_to_stop_time (sel_rp),
      .dmardy_n           (dmardy_n),
      .active_q           (tmr_active),
      .strobe_q           (strobe_pulse),
      .stop_ok_q          (stop_allowed)
   );

   assign xfer_active  = tmr_active;
   assign xfer_refused = refused_q;

   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         act_drive_q <= 2'h0;
         refused_q   <= 1'b0;
      end else begin
         refused_q <= xfer_start & ~tmr_active & ~xfer_stop & ~ok_all[xfer_drive];
         if (start_ok && !tmr_active && !xfer_stop) begin
            act_drive_q <= xfer_drive;
         end
      end
   end

   // Wishbone slave: ack one cycle after the request, dropped next cycle
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wb_ack_o            <= 1'b0;
         wb_dat_o            <= 32'h00000000;
         udma_cycle_timing_q <= `UDMATS_RST_CYCLE_TIMING;
         sync_en_q           <= `UDMATS_RST_SYNC_EN;
         clk_cfg_q           <= `UDMATS_RST_CLK_CFG;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_wr) begin
            case (wb_idx)
               `UDMATS_IDX_CYCLE_TIMING: begin
                  if (wb_sel_i[0]) begin
                     udma_cycle_timing_q[7:0] <= wb_dat_i[7:0] & cyc_mask[7:0]; // R3 R4
                  end
                  if (wb_sel_i[1]) begin
                     udma_cycle_timing_q[15:8] <= wb_dat_i[15:8] & cyc_mask[15:8]; // R1 R2
                  end
               end
               `UDMATS_IDX_SYNC_EN: begin
                  if (wb_sel_i[0]) begin
                     sync_en_q <= wb_dat_i[7:0] & `UDMATS_MASK_SYNC_EN; // R10
                  end
               end
               `UDMATS_IDX_CLK_CFG: begin
                  if (wb_sel_i[0]) begin
                     clk_cfg_q[7:0] <= wb_dat_i[7:0] & clk_mask[7:0]; // R8
                  end
                  if (wb_sel_i[1]) begin
                     clk_cfg_q[15:8] <= wb_dat_i[15:8] & clk_mask[15:8]; // R9
                  end
               end
               default: begin
                  udma_cycle_timing_q <= udma_cycle_timing_q;
               end
            endcase
         end
         if (wb_req) begin
            case (wb_idx)
               `UDMATS_IDX_CYCLE_TIMING: wb_dat_o <= {16'h0000, udma_cycle_timing_q};
               `UDMATS_IDX_SYNC_EN:      wb_dat_o <= {24'h000000, sync_en_q};
               `UDMATS_IDX_CLK_CFG:      wb_dat_o <= {16'h0000, clk_cfg_q};
               `UDMATS_IDX_STATUS: begin
                  wb_dat_o <= {10'h000, act_drive_q, tmr_active, stop_allowed,
                               valid_all, ok_all, 2'h0, sel_ct, sel_rp};
               end
               default: wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// ===== tb/udmats_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module udmats_monitor (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic xfer_start,
   input wire logic xfer_stop,
   input wire logic dmardy_n,
   input wire logic xfer_active,
   input wire logic strobe_pulse,
   input wire logic stop_allowed,
   input wire logic xfer_refused
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_start;
      xfer_start && !xfer_active && !xfer_stop;
   endsequence
   a_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack missing");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_start_answer: assert property (s_start |=> xfer_active || xfer_refused)
      else $error("start not answered");
   a_refuse_idle: assert property (xfer_refused |-> !xfer_active && !$past(xfer_active))
      else $error("refusal while running");
   a_strobe_gap: assert property (strobe_pulse |=> !strobe_pulse)
      else $error("strobe too close");
   a_strobe_busy: assert property (strobe_pulse |-> xfer_active) else $error("idle strobe");
   a_stop_ends: assert property (xfer_stop && xfer_active |-> ##[1:2] !xfer_active)
      else $error("stop ignored");
   a_allowed_ready: assert property (!dmardy_n |=> !stop_allowed)
      else $error("stop allowed while ready");
   a_allowed_wait: assert property ($rose(stop_allowed) |-> dmardy_n && $past(dmardy_n, 4))
      else $error("stop allowed too early");
endmodule
`default_nettype wire

// ===== tb/udmats_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
// Drive side: ready a few cycles after a burst starts, not ready while paused
module udmats_drive_model #(
   parameter int LAT = 2
) (
   input  wire logic core_clk,
   input  wire logic arst_n,
   input  wire logic xfer_active,
   input  wire logic pause,
   output logic      dmardy_n
);
   int cnt_q;
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= 0;
         dmardy_n <= 1'b1;
      end else begin
         cnt_q <= (xfer_active && !pause) ? cnt_q + 1 : 0;
         dmardy_n <= !(xfer_active && !pause && cnt_q >= LAT);
      end
   end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        core_clk, arst_n, cyc, stb, we, start, stop, pause;
   logic        ack, active, strobe, allowed, refused, dmardy_n;
   logic [1:0]  drive;
   logic [9:0]  adr;
   logic [31:0] wdat, rdat, dat_o;
   int          fail_count = 0, samples_checked = 0, n, i, d;
   // Per mode and code: {valid, ct, rp}; modes 33, 66, 133 MHz
   logic [8:0]  tbl [12] = '{9'h186, 9'h165, 9'h144, 9'h000, 9'h000, 9'h168,
                             9'h148, 9'h000, 9'h000, 9'h170, 9'h000, 9'h000};
   udmats_top DUT (.core_clk, .arst_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .xfer_start(start), .xfer_drive(drive), .xfer_stop(stop), .dmardy_n,
      .xfer_active(active), .strobe_pulse(strobe), .stop_allowed(allowed),
      .xfer_refused(refused));
   udmats_drive_model #(.LAT(2)) u_drv (.core_clk, .arst_n, .xfer_active(active), .pause,
      .dmardy_n);
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up;
      if (fail_count == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic bus(logic w, logic [9:0] a, logic [31:0] dv);
      int k;
      @(posedge core_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= dv;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1) begin
         check("bus ack", ack, 1);
         wrap_up();
      end
   endtask
   task automatic pulse(logic is_stop);
      @(posedge core_clk);
      if (is_stop)
         stop <= 1'b1;
      else
         start <= 1'b1;
      @(posedge core_clk);
      start <= 1'b0;
      stop <= 1'b0;
      #1;
   endtask
   // Watched signal: 0 strobe, 1 drive not ready, 2 stop allowed
   function automatic logic pick(int w);
      return (w == 0) ? strobe : ((w == 1) ? dmardy_n : allowed);
   endfunction
   task automatic wait_hi(int w);
      n = 0;
      while (pick(w) !== 1'b1 && n < 200) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n >= 200) begin
         check("wait", pick(w), 1);
         wrap_up();
      end
   endtask
   initial begin
      {arst_n, cyc, stb, we, start, stop, pause, drive, adr, wdat} = '0;
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b1;
      bus(1'b0, 10'h128, 0);
      check("timing reset", rdat, 0);
      bus(1'b0, 10'h120, 0);
      check("enable reset", rdat, 0);
      bus(1'b1, 10'h128, 32'hffff);
      bus(1'b0, 10'h128, 0);
      check("timing rw", rdat, 32'h3333);
      bus(1'b1, 10'h3fc, 32'hffff);
      bus(1'b0, 10'h3fc, 0);
      check("unmapped", rdat, 0);
      for (i = 0; i < 12; i++) begin
         d = (i + i / 4) % 4;
         bus(1'b1, 10'h128, 32'(i % 4) << (4 * d));
         bus(1'b1, 10'h150, 32'(i >= 4) << d | 32'(i >= 8) << (12 + d));
         drive <= 2'(d);
         bus(1'b0, 10'h180, 0);
         check("code valid", rdat[14 + d], tbl[i][8]);
         if (tbl[i][8])
            check("ct rp", rdat[7:0], tbl[i][7:0]);
      end
      bus(1'b1, 10'h128, 0);
      bus(1'b1, 10'h150, 0);
      bus(1'b1, 10'h120, 0);
      drive <= 2'h0;
      pulse(1'b0);
      check("refused", refused, 1);
      bus(1'b1, 10'h120, 1);
      pulse(1'b0);
      check("active", active, 1);
      wait_hi(0);
      @(posedge core_clk);
      #1;
      wait_hi(0);
      check("strobe gap", n + 1, 4);
      pause <= 1'b1;
      wait_hi(1);
      wait_hi(2);
      check("ready to stop", n, 7);
      pulse(1'b1);
      check("stopped", active, 0);
      wrap_up();
   end
endmodule
bind udmats_top udmats_monitor u_mon (.core_clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
   .xfer_start, .xfer_stop, .dmardy_n, .xfer_active, .strobe_pulse, .stop_allowed,
   .xfer_refused);
`default_nettype wire
